/* logic/tcm_defines.svh */
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH
// frame layout, 64 bits in all
`define TCM_ADDR_W      16
`define TCM_DATA_W      8
`define TCM_CYC_W       2
`define TCM_PROBE_W     8
`define TCM_FRAME_W     64
`define TCM_ROWS        8
`define TCM_FIELDS      7
// register map (word addresses on the plain port)
`define TCM_REG_ADDR_W  8
`define TCM_RG_SEL      8'h00
`define TCM_RG_VAL0     8'h01
`define TCM_RG_VAL1     8'h02
`define TCM_RG_CARE0    8'h03
`define TCM_RG_CARE1    8'h04
`define TCM_RG_HIGH     8'h05
`define TCM_RG_CTRL     8'h06
`define TCM_RG_STAT     8'h07
// selector fields
`define TCM_SEL_LIST    3
`define TCM_SEL_ROW_HI  2
// control fields
`define TCM_CTL_FILT_LO 0
`define TCM_CTL_SEQ     2
`define TCM_CTL_CLR     3
// row enable field inside high word
`define TCM_EN_LO       16
`define TCM_RANGE_BIT   23
`endif

/* logic/tcm_pkg.sv */
package tcm_pkg;
  typedef enum logic [1:0] {
    TCM_FILT_ALL  = 2'h0,
    TCM_FILT_A    = 2'h1,
    TCM_FILT_B    = 2'h3,
    TCM_FILT_AB   = 2'h2
  } tcm_filter_t;
  typedef enum logic [1:0] {
    TCM_SQ_IDLE   = 2'h0,
    TCM_SQ_ARMED  = 2'h1,
    TCM_SQ_HIT    = 2'h3
  } tcm_seq_t;
endpackage : tcm_pkg

/* logic/tcm_cond_if.sv */
`include "tcm_defines.svh"
interface tcm_cond_if;
  logic                     frame_valid;
  logic [`TCM_FRAME_W-1:0]  frame;
  logic                     list_a;
  logic                     list_b;
  modport source (output frame_valid, output frame, input list_a, input list_b);
  modport sink   (input frame_valid, input frame, output list_a, output list_b);
endinterface : tcm_cond_if

/* logic/tcm_list_eval.sv */
`include "tcm_defines.svh"
module tcm_list_eval #(
  parameter int ROWS = `TCM_ROWS
) (
  input  wire logic [`TCM_FRAME_W-1:0]         frame_in,
  input  wire logic [ROWS*`TCM_FRAME_W-1:0]    value_in,
  input  wire logic [ROWS*`TCM_FRAME_W-1:0]    care_in,
  input  wire logic [ROWS*`TCM_ADDR_W-1:0]     high_in,
  input  wire logic [ROWS*`TCM_FIELDS-1:0]     field_en_in,
  input  wire logic [ROWS-1:0]                 range_in,
  output logic                                 met_out
);
  import tcm_pkg::*;

  // field f bit span within the frame: addr, e0, e1, cyc, data, probe_lo, probe_hi
  function automatic logic [`TCM_FRAME_W-1:0] field_mask(input int f);
    logic [`TCM_FRAME_W-1:0] m;
    m = '0;
    case (f)
      0: m[15:0]  = '1;
      1: m[16]    = 1'b1;
      2: m[17]    = 1'b1;
      3: m[19:18] = '1;
      4: m[27:20] = '1;
      5: m[35:28] = '1;
      6: m[43:36] = '1;
      default: m = '0;
    endcase
    return m;
  endfunction : field_mask

  logic [ROWS-1:0] hit [`TCM_FIELDS];
  logic [`TCM_FIELDS-1:0] col_or;

  for (genvar r = 0; r < ROWS; r++) begin : g_row
    wire [`TCM_FRAME_W-1:0] v  = value_in[r*`TCM_FRAME_W +: `TCM_FRAME_W];
    wire [`TCM_FRAME_W-1:0] c  = care_in[r*`TCM_FRAME_W +: `TCM_FRAME_W];
    wire [`TCM_ADDR_W-1:0]  hi = high_in[r*`TCM_ADDR_W +: `TCM_ADDR_W];
    wire [`TCM_ADDR_W-1:0]  fa = frame_in[`TCM_ADDR_W-1:0];
    wire [`TCM_FRAME_W-1:0] diff = (frame_in ^ v) & c;
    wire in_range = (fa >= v[`TCM_ADDR_W-1:0]) && (fa <= hi);
    for (genvar f = 0; f < `TCM_FIELDS; f++) begin : g_fld
      wire cmp = (f == 0 && range_in[r]) ? in_range : ((diff & field_mask(f)) == '0);
      // blank cells never feed the column result
      assign hit[f][r] = field_en_in[r*`TCM_FIELDS + f] && cmp;
    end
  end

  for (genvar f = 0; f < `TCM_FIELDS; f++) begin : g_col
    assign col_or[f] = |hit[f];
  end
  assign met_out = &col_or;
endmodule : tcm_list_eval

/* logic/tcm_matcher.sv */
`include "tcm_defines.svh"
module tcm_matcher #(
  parameter int ROWS = `TCM_ROWS
) (
  // clock and reset
  input  wire logic                        clock_in,
  input  wire logic                        rst_n_in,
  // traced bus (asynchronous pins)
  input  wire logic                        cycle_strobe_in,
  input  wire logic [`TCM_ADDR_W-1:0]      bus_addr_in,
  input  wire logic [`TCM_DATA_W-1:0]      bus_data_in,
  input  wire logic                        extra_bus_bit_zero_in,
  input  wire logic                        extra_bus_bit_one_in,
  input  wire logic [`TCM_CYC_W-1:0]       cycle_type_in,
  input  wire logic [`TCM_PROBE_W-1:0]     probe_group_low_in,
  input  wire logic [`TCM_PROBE_W-1:0]     probe_group_high_in,
  // register port
  input  wire logic [`TCM_REG_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [31:0]                 reg_wdata_in,
  input  wire logic                        reg_write_in,
  input  wire logic                        reg_read_in,
  output logic      [31:0]                 reg_rdata_out,
  // results
  output logic                             frame_valid_out,
  output logic [`TCM_FRAME_W-1:0]          frame_out,
  output logic                             cond_a_out,
  output logic                             cond_b_out,
  output logic                             record_out,
  output logic                             seq_hit_out
);
  import tcm_pkg::*;

  if (ROWS < 1 || ROWS > `TCM_ROWS) begin : g_bad_rows
    $error("ROWS must be 1..8");
  end

  // pin synchronisers: two flops before any logic
  localparam int PW = 1 + `TCM_FRAME_W;
  logic [PW-1:0] pin_s1, pin_s2;
  logic          strobe_d;
  wire  [PW-1:0] pin_raw = {cycle_strobe_in, 20'h00000, probe_group_high_in,
                            probe_group_low_in, bus_data_in, cycle_type_in,
                            extra_bus_bit_one_in, extra_bus_bit_zero_in, bus_addr_in};
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1   <= '0;
      pin_s2   <= '0;
      strobe_d <= 1'b0;
    end else begin
      pin_s1   <= pin_raw;
      pin_s2   <= pin_s1;
      strobe_d <= pin_s2[PW-1];
    end
  end
  wire take_frame = pin_s2[PW-1] && !strobe_d;

  // frame capture: all fields, probes included, on the same edge
  tcm_cond_if cif ();
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cif.frame       <= '0;
      cif.frame_valid <= 1'b0;
    end else begin
      cif.frame_valid <= take_frame;
      if (take_frame) cif.frame <= pin_s2[`TCM_FRAME_W-1:0];
    end
  end

  // qualifier storage
  logic [`TCM_FRAME_W-1:0] q_val  [2][ROWS];
  logic [`TCM_FRAME_W-1:0] q_care [2][ROWS];
  logic [`TCM_ADDR_W-1:0]  q_high [2][ROWS];
  logic [`TCM_FIELDS-1:0]  q_en   [2][ROWS];
  logic                    q_rng  [2][ROWS];
  logic [3:0]              sel;
  logic [1:0]              filt_mode;
  logic                    seq_mode;
  logic [31:0]             rdata;

  wire       sel_list = sel[`TCM_SEL_LIST];
  wire [2:0] sel_row  = sel[`TCM_SEL_ROW_HI:0];
  wire       row_ok   = 32'(sel_row) < ROWS;
  wire       wr_sel   = reg_write_in && reg_addr_in == `TCM_RG_SEL;
  wire       wr_ctrl  = reg_write_in && reg_addr_in == `TCM_RG_CTRL;
  wire       clr_seq  = wr_ctrl && reg_wdata_in[`TCM_CTL_CLR];

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel       <= '0;
      filt_mode <= '0;
      seq_mode  <= 1'b0;
      for (int l = 0; l < 2; l++) begin
        for (int r = 0; r < ROWS; r++) begin
          q_val[l][r]  <= '0;
          q_care[l][r] <= '0;
          q_high[l][r] <= '0;
          q_en[l][r]   <= '0;
          q_rng[l][r]  <= 1'b0;
        end
      end
    end else if (reg_write_in) begin
      if (wr_sel) sel <= reg_wdata_in[3:0];
      if (wr_ctrl) begin
        filt_mode <= reg_wdata_in[`TCM_CTL_FILT_LO +: 2];
        seq_mode  <= reg_wdata_in[`TCM_CTL_SEQ];
      end
      if (row_ok) begin
        case (reg_addr_in)
          `TCM_RG_VAL0:  q_val[sel_list][sel_row][31:0]   <= reg_wdata_in;
          `TCM_RG_VAL1:  q_val[sel_list][sel_row][63:32]  <= reg_wdata_in;
          `TCM_RG_CARE0: q_care[sel_list][sel_row][31:0]  <= reg_wdata_in;
          `TCM_RG_CARE1: q_care[sel_list][sel_row][63:32] <= reg_wdata_in;
          `TCM_RG_HIGH: begin
            // upper bound is already inclusive; start+len-1 done by software
            q_high[sel_list][sel_row] <= reg_wdata_in[`TCM_ADDR_W-1:0];
            q_en[sel_list][sel_row]   <= reg_wdata_in[`TCM_EN_LO +: `TCM_FIELDS];
            q_rng[sel_list][sel_row]  <= reg_wdata_in[`TCM_RANGE_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // flatten one list for the evaluator
  function automatic logic [ROWS*`TCM_FRAME_W-1:0] pack64(
      input logic [`TCM_FRAME_W-1:0] a [ROWS]);
    logic [ROWS*`TCM_FRAME_W-1:0] p;
    p = '0;
    for (int r = 0; r < ROWS; r++) p[r*`TCM_FRAME_W +: `TCM_FRAME_W] = a[r];
    return p;
  endfunction : pack64

  logic [ROWS*`TCM_ADDR_W-1:0] hi_flat [2];
  logic [ROWS*`TCM_FIELDS-1:0] en_flat [2];
  logic [ROWS-1:0]             rg_flat [2];
  logic                        met [2];
  always_comb begin
    for (int l = 0; l < 2; l++) begin
      hi_flat[l] = '0;
      en_flat[l] = '0;
      rg_flat[l] = '0;
      for (int r = 0; r < ROWS; r++) begin
        hi_flat[l][r*`TCM_ADDR_W +: `TCM_ADDR_W] = q_high[l][r];
        en_flat[l][r*`TCM_FIELDS +: `TCM_FIELDS] = q_en[l][r];
        rg_flat[l][r] = q_rng[l][r];
      end
    end
  end

  // both lists run in parallel on the captured frame
  for (genvar l = 0; l < 2; l++) begin : g_list
    tcm_list_eval #(.ROWS(ROWS)) u_eval (
      .frame_in    (cif.frame),
      .value_in    (pack64(q_val[l])),
      .care_in     (pack64(q_care[l])),
      .high_in     (hi_flat[l]),
      .field_en_in (en_flat[l]),
      .range_in    (rg_flat[l]),
      .met_out     (met[l])
    );
  end
  assign cif.list_a = met[0];
  assign cif.list_b = met[1];

  // registered results, one cycle after the frame
  tcm_seq_t seq_state, next_seq_state;
  always_comb begin
    next_seq_state = seq_state;
    case (seq_state)
      TCM_SQ_IDLE:  if (cif.frame_valid && cif.list_a) next_seq_state = TCM_SQ_ARMED;
      TCM_SQ_ARMED: if (cif.frame_valid && cif.list_b) next_seq_state = TCM_SQ_HIT;
      TCM_SQ_HIT:   next_seq_state = TCM_SQ_HIT;
      default:      next_seq_state = TCM_SQ_IDLE;
    endcase
    if (clr_seq) next_seq_state = TCM_SQ_IDLE;
  end

  wire b_counts = seq_mode ? (seq_state == TCM_SQ_ARMED) && cif.list_b : cif.list_b;
  logic next_record;
  always_comb begin
    case (tcm_filter_t'(filt_mode))
      TCM_FILT_ALL: next_record = 1'b1;
      TCM_FILT_A:   next_record = cif.list_a;
      TCM_FILT_B:   next_record = cif.list_b;
      TCM_FILT_AB:  next_record = cif.list_a && cif.list_b;
      default:      next_record = 1'b1;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_valid_out <= 1'b0;
      frame_out       <= '0;
      cond_a_out      <= 1'b0;
      cond_b_out      <= 1'b0;
      record_out      <= 1'b0;
      seq_hit_out     <= 1'b0;
      seq_state       <= TCM_SQ_IDLE;
    end else begin
      seq_state       <= next_seq_state;
      frame_valid_out <= cif.frame_valid;
      if (cif.frame_valid) begin
        frame_out   <= cif.frame;
        cond_a_out  <= cif.list_a;
        cond_b_out  <= b_counts;
        record_out  <= next_record;
      end
      seq_hit_out <= next_seq_state == TCM_SQ_HIT;
    end
  end

  // register readback
  wire [31:0] stat_word = {28'h0000000, seq_state == TCM_SQ_HIT,
                           seq_state == TCM_SQ_ARMED, cond_b_out, cond_a_out};
  always_comb begin
    case (reg_addr_in)
      `TCM_RG_SEL:   rdata = {28'h0000000, sel};
      `TCM_RG_VAL0:  rdata = q_val[sel_list][sel_row][31:0];
      `TCM_RG_VAL1:  rdata = q_val[sel_list][sel_row][63:32];
      `TCM_RG_CARE0: rdata = q_care[sel_list][sel_row][31:0];
      `TCM_RG_CARE1: rdata = q_care[sel_list][sel_row][63:32];
      `TCM_RG_HIGH:  rdata = {8'h00, q_rng[sel_list][sel_row], q_en[sel_list][sel_row],
                             q_high[sel_list][sel_row]};
      `TCM_RG_CTRL:  rdata = {29'h00000000, seq_mode, filt_mode};
      `TCM_RG_STAT:  rdata = stat_word;
      default:       rdata = 32'h00000000;
    endcase
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) reg_rdata_out <= '0;
    else           reg_rdata_out <= reg_read_in ? rdata : 32'h00000000;
  end

  // checks
  a_result_follows_frame: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cif.frame_valid |=> frame_valid_out && cond_a_out == $past(cif.list_a))
    else $error("a result not registered one cycle after frame");
  a_filter_a_only: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cif.frame_valid && filt_mode == TCM_FILT_A |=> record_out == cond_a_out)
    else $error("filter A record mismatch");
  a_filter_both: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cif.frame_valid && filt_mode == TCM_FILT_AB |=> record_out == (cond_a_out && $past(cif.list_b)))
    else $error("filter A and B record mismatch");
  a_seq_b_after_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    seq_mode && seq_state == TCM_SQ_IDLE && cif.frame_valid |=> !cond_b_out)
    else $error("b counted before a in sequential mode");
  a_seq_reaches_hit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    seq_state == TCM_SQ_ARMED && cif.frame_valid && cif.list_b && !clr_seq |=> seq_hit_out)
    else $error("sequence did not complete on b");
  a_frame_capture: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    take_frame |=> cif.frame == $past(pin_s2[`TCM_FRAME_W-1:0]) ##1 frame_out == $past(cif.frame))
    else $error("frame not captured whole");
  a_no_care_hits: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    q_en[0][0] == 7'h7F && q_care[0][0] == '0 && !q_rng[0][0] |-> cif.list_a)
    else $error("all dont-care qualifier failed to match");
  a_blank_list_fails: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    en_flat[1] == '0 |-> !cif.list_b)
    else $error("blank list reported a match");
  a_blank_a_fails: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    en_flat[0] == '0 |-> !cif.list_a)
    else $error("blank list A reported a match");

  // output timing and readback
  a_valid_one_pulse: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    frame_valid_out |=> !frame_valid_out)
    else $error("frame valid longer than one cycle");
  a_valid_source: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    frame_valid_out |-> $past(cif.frame_valid))
    else $error("frame valid without a captured frame");
  a_take_once: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    take_frame |=> !take_frame)
    else $error("one strobe taken twice");
  a_result_b_plain: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cif.frame_valid && !seq_mode |=> cond_b_out == $past(cif.list_b))
    else $error("b result not registered one cycle after frame");
  a_results_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !cif.frame_valid |=> $stable(cond_a_out) && $stable(cond_b_out) &&
    $stable(record_out))
    else $error("results changed without a frame");
  a_frame_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !cif.frame_valid |=> $stable(frame_out))
    else $error("frame changed without a strobe");
  a_record_all: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cif.frame_valid && filt_mode == TCM_FILT_ALL |=> record_out)
    else $error("filter all dropped a frame");
  a_filter_b_only: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cif.frame_valid && filt_mode == TCM_FILT_B |=> record_out == $past(cif.list_b))
    else $error("filter B record mismatch");
  a_seq_armed_on_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    seq_state == TCM_SQ_IDLE && cif.frame_valid && cif.list_a && !clr_seq |=>
    seq_state == TCM_SQ_ARMED)
    else $error("a match did not arm the sequence");
  a_seq_armed_holds: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    seq_state == TCM_SQ_ARMED && !(cif.frame_valid && cif.list_b) && !clr_seq |=>
    seq_state == TCM_SQ_ARMED)
    else $error("armed sequence lost without b");
  a_seq_b_gated: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    seq_mode && cif.frame_valid |=>
    cond_b_out == ($past(seq_state) == TCM_SQ_ARMED && $past(cif.list_b)))
    else $error("sequential b result not gated by arming");
  a_seq_hit_holds: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    seq_state == TCM_SQ_HIT && !clr_seq |=> seq_hit_out)
    else $error("sequence hit dropped before clear");
  a_seq_idle_no_hit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    seq_state == TCM_SQ_IDLE |=> !seq_hit_out)
    else $error("hit reached without arming");
  a_seq_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clr_seq |=> seq_state == TCM_SQ_IDLE && !seq_hit_out)
    else $error("sequence not cleared");
  a_seq_hit_level: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    seq_hit_out == (seq_state == TCM_SQ_HIT))
    else $error("hit output differs from sequence state");
  a_rdata_idle_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !reg_read_in |=> reg_rdata_out == 32'h00000000)
    else $error("read data outside a read cycle");
  a_rdata_unmapped: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    reg_read_in && reg_addr_in > `TCM_RG_STAT |=> reg_rdata_out == 32'h00000000)
    else $error("unmapped register read not zero");
  a_stat_mirror: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    reg_read_in && reg_addr_in == `TCM_RG_STAT |=>
    reg_rdata_out[1:0] == {$past(cond_b_out), $past(cond_a_out)})
    else $error("status does not mirror results");
  a_ctrl_readback: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    reg_read_in && reg_addr_in == `TCM_RG_CTRL |=>
    reg_rdata_out == {29'h00000000, $past(seq_mode), $past(filt_mode)})
    else $error("control readback mismatch");
  a_sel_readback: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    reg_read_in && reg_addr_in == `TCM_RG_SEL |=> reg_rdata_out == {28'h0000000, $past(sel)})
    else $error("select readback mismatch");
endmodule : tcm_matcher

/* tb/tcm_bus_model.sv */
module tcm_bus_model (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // request from the bench
  input  wire logic        send_in,
  input  wire logic [43:0] frame_in,
  // traced pins
  output logic             strobe_out,
  output logic [43:0]      pins_out,
  output logic             busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] step;
  assign busy_out = (step != 3'h0);
  // pins settle a cycle before the strobe and are inverted once their hold has run out
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      step       <= 3'h0;
      strobe_out <= 1'b0;
      pins_out   <= 44'h5A5_A5A5_A5A5;
    end else if (step == 3'h0) begin
      if (send_in) begin
        pins_out <= frame_in;
        step     <= 3'h1;
      end
    end else begin
      step <= step + 3'h1;
      if (step == 3'h1) begin
        strobe_out <= 1'b1;
      end
      if (step == 3'h3) begin
        strobe_out <= 1'b0;
      end
      if (step == 3'h5) begin
        pins_out <= ~pins_out;
      end
    end
  end
endmodule : tcm_bus_model

/* tb/trace_condition_matcher_test.sv */
`include "tcm_defines.svh"
module trace_condition_matcher_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tcm_pkg::*;
  localparam logic [43:0] FA = {8'h00, 8'hC3, 8'h5A, 2'h2, 1'h0, 1'h1, 16'h6005};
  localparam logic [43:0] PH = 44'h3C0_0000_0000;
  localparam logic [43:0] DB = 44'h000_0010_0000;
  localparam logic [43:0] AM = 44'h000_0000_FFFF;
  logic        clock_in;
  logic        rst_n_in;
  logic        send;
  logic        strobe;
  logic        busy;
  logic [43:0] frame;
  logic [43:0] pins;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_write;
  logic        reg_read;
  logic        frame_valid;
  logic [63:0] frame_cap;
  logic        cond_a;
  logic        cond_b;
  logic        record;
  logic        seq_hit;
  int          err_count;
  int          tests_run;

  tcm_matcher tcm_matcher_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .cycle_strobe_in(strobe),
    .bus_addr_in(pins[15:0]), .bus_data_in(pins[27:20]),
    .extra_bus_bit_zero_in(pins[16]), .extra_bus_bit_one_in(pins[17]),
    .cycle_type_in(pins[19:18]), .probe_group_low_in(pins[35:28]),
    .probe_group_high_in(pins[43:36]), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_write_in(reg_write), .reg_read_in(reg_read),
    .reg_rdata_out(reg_rdata), .frame_valid_out(frame_valid), .frame_out(frame_cap),
    .cond_a_out(cond_a), .cond_b_out(cond_b), .record_out(record),
    .seq_hit_out(seq_hit));
  tcm_bus_model tcm_bus_model_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .send_in(send), .frame_in(frame),
    .strobe_out(strobe), .pins_out(pins), .busy_out(busy));

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock_in);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock_in);
    reg_read <= 1'b0;
    @(posedge clock_in);
    check(reg_rdata, exp, "read data");
  endtask : rd
  task automatic row(input logic l, input logic [2:0] r, input logic [43:0] v,
                     input logic [43:0] c, input logic [15:0] hi, input logic [6:0] en,
                     input logic rng);
    wr(`TCM_RG_SEL, {28'h0, l, r});
    wr(`TCM_RG_VAL0, v[31:0]);
    wr(`TCM_RG_VAL1, {20'h0, v[43:32]});
    wr(`TCM_RG_CARE0, c[31:0]);
    wr(`TCM_RG_CARE1, {20'h0, c[43:32]});
    wr(`TCM_RG_HIGH, {8'h00, rng, en, hi});
  endtask : row
  // one traced cycle; results are judged in the cycle that marks them valid
  task automatic cyc(input logic [43:0] f, input logic ea, input logic eb, input logic er);
    int n;
    @(posedge clock_in);
    send  <= 1'b1;
    frame <= f;
    @(posedge clock_in);
    send <= 1'b0;
    n = 0;
    while (frame_valid !== 1'b1 && n < 20) begin
      @(posedge clock_in);
      n++;
    end
    check(n < 20, 1, "frame seen");
    check({cond_a, cond_b, record}, {ea, eb, er}, "results");
    check(frame_cap, {20'h0, f}, "captured frame");
    @(posedge clock_in);
    check(frame_valid, 1'b0, "valid one cycle");
    while (busy === 1'b1) @(posedge clock_in);
  endtask : cyc

  task automatic t_reset;
    rd(`TCM_RG_STAT, 32'h0);
    rd(8'h20, 32'h0);
    cyc(FA, 1'b0, 1'b0, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_exact;
    row(1'b0, 3'h0, FA, {44{1'b1}}, 16'h0, 7'h7F, 1'b0);
    rd(`TCM_RG_VAL0, FA[31:0]);
    cyc(FA, 1'b1, 1'b0, 1'b1);
    cyc(FA ^ DB, 1'b0, 1'b0, 1'b1);
    row(1'b0, 3'h0, FA, ~44'h000_0FF0_0000, 16'h0, 7'h7F, 1'b0);
    cyc(FA ^ DB, 1'b1, 1'b0, 1'b1);
    $display("exact test done");
  endtask : t_exact
  task automatic t_or;
    row(1'b0, 3'h0, FA, AM, 16'h0, 7'h01, 1'b0);
    row(1'b0, 3'h7, FA & ~AM | 44'h1234, 44'h00F_FFFF_0000, 16'h0, 7'h7E, 1'b0);
    cyc(FA, 1'b1, 1'b0, 1'b1);
    cyc(FA & ~AM | 44'h1234, 1'b0, 1'b0, 1'b1);
    cyc(FA ^ DB, 1'b0, 1'b0, 1'b1);
    cyc(FA | PH, 1'b1, 1'b0, 1'b1);
    $display("or test done");
  endtask : t_or
  task automatic t_range;
    logic [15:0] ad [4] = '{16'h6000, 16'h601F, 16'h6020, 16'h5FFF};
    logic [15:0] hi;
    hi = 16'h6000 + 16'h0020 - 16'h0001;
    row(1'b1, 3'h0, PH | 44'h6000, 44'hFF0_0000_FFFF, hi, 7'h7F, 1'b1);
    for (int i = 0; i < 4; i++) begin
      cyc((FA | PH) & ~AM | 44'(ad[i]), 1'b0, i < 2, 1'b1);
    end
    $display("range test done");
  endtask : t_range
  task automatic t_filter;
    logic [43:0] f [4];
    tcm_filter_t md [4] = '{TCM_FILT_ALL, TCM_FILT_A, TCM_FILT_B, TCM_FILT_AB};
    logic [3:0] ea = 4'b0011;
    logic [3:0] eb = 4'b0101;
    f = '{FA | PH, FA, (FA | PH) & ~AM | 44'h6010, FA & ~AM | 44'h7000};
    for (int m = 0; m < 4; m++) begin
      wr(`TCM_RG_CTRL, {30'h0, md[m]});
      for (int i = 0; i < 4; i++) begin
        cyc(f[i], ea[i], eb[i], (m == 0) | (m == 1 && ea[i]) | (m == 2 && eb[i]) |
            (m == 3 && ea[i] && eb[i]));
      end
    end
    $display("filter test done");
  endtask : t_filter
  task automatic t_seq;
    wr(`TCM_RG_CTRL, 32'hC);
    cyc((FA | PH) & ~AM | 44'h6010, 1'b0, 1'b0, 1'b1);
    check(seq_hit, 1'b0, "hit before A");
    cyc(FA | PH, 1'b1, 1'b0, 1'b1);
    check(seq_hit, 1'b0, "hit on same frame");
    cyc((FA | PH) & ~AM | 44'h6010, 1'b0, 1'b1, 1'b1);
    check(seq_hit, 1'b1, "hit after A then B");
    rd(`TCM_RG_STAT, 32'h0000000A);
    wr(`TCM_RG_CTRL, 32'hC);
    repeat (2) @(posedge clock_in);
    check(seq_hit, 1'b0, "hit cleared");
    $display("sequence test done");
  endtask : t_seq

  // an all don't-care row matches any frame on every field
  task automatic t_wild;
    row(1'b0, 3'h0, 44'h0, 44'h0, 16'h0, 7'h7F, 1'b0);
    cyc(44'h0, 1'b1, 1'b0, 1'b1);
    $display("wildcard test done");
  endtask : t_wild

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    rst_n_in  = 1'b0;
    send      = 1'b0;
    frame     = 44'h0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_exact;
    t_or;
    t_range;
    t_filter;
    t_seq;
    t_wild;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict;
  end
endmodule : trace_condition_matcher_test
